// *** rtl/cpu_addr_pkg.sv ***
// shared constants, types and pointer decode for the program and data addressing core
package cpu_addr_pkg;
   localparam int PC_W = 15;
   localparam int STACK_DEPTH = 16;
   localparam int DEPTH_W = 5;
   localparam int PTR_W = 16;
   localparam int PROG_W = 14;
   localparam int DATA_AW = 12;
   localparam int BANK_W = 5;
   localparam int OFS_W = 7;
   localparam int REG_AW = 4;
   localparam int BUS_W = 16;
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] INT_VECTOR = 15'h0004;
   localparam logic [14:0] PROG_TOP = 15'h0FFF;
   // bit 7 of the pointer high byte
   localparam int PTR_PROG_BIT = 15;
   localparam logic [15:0] TRAD_END = 16'h0FFF;
   localparam logic [15:0] LIN_BASE = 16'h2000;
   localparam logic [15:0] LIN_END = 16'h29AF;
   localparam logic [11:0] GPR_BYTES = 12'h050;
   localparam logic [6:0] GPR_FIRST = 7'h20;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_POWER_CONTROL_REGISTER = 4'h1;
   localparam logic [3:0] REG_MASK = 4'h2;
   localparam logic [3:0] REG_PTR0 = 4'h3;
   localparam logic [3:0] REG_PTR1 = 4'h4;
   localparam logic [3:0] REG_BANK = 4'h5;
   localparam logic [3:0] REG_WORK = 4'h6;
   localparam logic [3:0] REG_PC = 4'h7;
   localparam logic [3:0] REG_DEPTH = 4'h8;
   localparam int CTRL_STACK_RESET_BIT = 0;
   localparam int POWER_CONTROL_REGISTER_OVF_BIT = 0;
   localparam int POWER_CONTROL_REGISTER_UNF_BIT = 1;
   localparam logic CTRL_RESET = 1'h0;
   localparam logic [1:0] POWER_CONTROL_REGISTER_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [4:0] BANK_RESET = 5'h00;
   localparam logic [7:0] WORK_RESET = 8'h00;

   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_DATA = 2'b01,
      ACC_PROG_EXTRA = 2'b10,
      ACC_PROG_LATCH = 2'b11
   } access_state_e;

   // returns {hit, data address}; hit low means the pointer reaches no data memory
   function automatic logic [12:0] map_pointer(input logic [15:0] ptr);
      logic [11:0] ofs;
      logic [11:0] lin_bank;
      logic [11:0] idx;
      logic [6:0] in_bank;
      ofs = 12'(ptr - LIN_BASE);
      lin_bank = ofs / GPR_BYTES;
      idx = ofs % GPR_BYTES;
      in_bank = idx[6:0] + GPR_FIRST;
      if (ptr <= TRAD_END) begin
         map_pointer = {1'b1, ptr[11:0]};
      end else if (ptr >= LIN_BASE && ptr <= LIN_END) begin
         map_pointer = {1'b1, lin_bank[4:0], in_bank};
      end else begin
         map_pointer = 13'h0000;
      end
   endfunction : map_pointer
endpackage : cpu_addr_pkg

// *** rtl/return_stack.sv ***
// sixteen-entry return-address stack with overflow and underflow detection
`timescale 1ns/1ps
module return_stack (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic push,
   input wire logic pop,
   input wire logic [cpu_addr_pkg::PC_W-1:0] push_addr,
   output logic [cpu_addr_pkg::PC_W-1:0] top_addr,
   output logic [cpu_addr_pkg::DEPTH_W-1:0] depth,
   output logic overflow,
   output logic underflow
);
   import cpu_addr_pkg::*;

   logic [PC_W-1:0] mem [STACK_DEPTH];
   logic [DEPTH_W-1:0] count;
   logic [DEPTH_W-1:0] below;

   assign below = count - 5'h01;
   assign overflow = push && count == DEPTH_W'(STACK_DEPTH);
   assign underflow = pop && count == 5'h00;
   assign top_addr = (count == 5'h00) ? 15'h0000 : mem[below[3:0]];
   assign depth = count;

   // a full stack keeps its entries; the lost push is only reported
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 5'h00;
      end else if (clear) begin
         count <= 5'h00;
      end else if (push && !overflow) begin
         count <= count + 5'h01;
      end else if (pop && !underflow) begin
         count <= below;
      end
   end

   always_ff @(posedge clk) begin
      if (push && !overflow && !clear) begin
         mem[count[3:0]] <= push_addr;
      end
   end
endmodule : return_stack

// *** rtl/context_shadow.sv ***
// shadow copies of core registers taken on interrupt entry
`timescale 1ns/1ps
module context_shadow (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic save,
   input wire logic [7:0] work_in,
   input wire logic [cpu_addr_pkg::BANK_W-1:0] bank_in,
   input wire logic [cpu_addr_pkg::PTR_W-1:0] ptr0_in,
   input wire logic [cpu_addr_pkg::PTR_W-1:0] ptr1_in,
   output logic [7:0] work_sh,
   output logic [cpu_addr_pkg::BANK_W-1:0] bank_sh,
   output logic [cpu_addr_pkg::PTR_W-1:0] ptr0_sh,
   output logic [cpu_addr_pkg::PTR_W-1:0] ptr1_sh
);
   import cpu_addr_pkg::*;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         work_sh <= WORK_RESET;
         bank_sh <= BANK_RESET;
         ptr0_sh <= PTR_RESET;
         ptr1_sh <= PTR_RESET;
      end else if (save) begin
         work_sh <= work_in;
         bank_sh <= bank_in;
         ptr0_sh <= ptr0_in;
         ptr1_sh <= ptr1_in;
      end
   end
endmodule : context_shadow

// *** rtl/cpu_program_memory_access.sv ***
// program counter, return stack, indirect pointers and context shadows of the cpu core
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module cpu_program_memory_access (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [cpu_addr_pkg::REG_AW-1:0] reg_addr,
   input wire logic [cpu_addr_pkg::BUS_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [cpu_addr_pkg::BUS_W-1:0] reg_rdata,
   input wire logic step,
   input wire logic jump,
   input wire logic [cpu_addr_pkg::PC_W-1:0] jump_target,
   input wire logic call,
   input wire logic [cpu_addr_pkg::PC_W-1:0] call_target,
   input wire logic ret,
   input wire logic retfie,
   input wire logic int_req,
   input wire logic dir_rd,
   input wire logic dir_wr,
   input wire logic [cpu_addr_pkg::OFS_W-1:0] dir_ofs,
   input wire logic ind_rd,
   input wire logic ind_wr,
   input wire logic ind_sel,
   input wire logic [7:0] wr_data,
   input wire logic [cpu_addr_pkg::PROG_W-1:0] prog_rdata,
   input wire logic [7:0] data_rdata,
   output logic [cpu_addr_pkg::PC_W-1:0] prog_addr,
   output logic [cpu_addr_pkg::DATA_AW-1:0] data_addr,
   output logic data_rd,
   output logic data_wr,
   output logic [7:0] data_wdata,
   output logic [7:0] wreg,
   output logic busy,
   output logic soft_reset,
   output logic irq
);
   import cpu_addr_pkg::*;

   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [PTR_W-1:0] ptr0;
   logic [PTR_W-1:0] ptr1;
   logic [BANK_W-1:0] bank;
   logic ctrl_stack_reset;
   logic [1:0] power_control_register;
   logic [1:0] mask;
   logic [1:0] power_control_register_set;
   logic [1:0] power_control_register_clr;
   access_state_e acc_state;
   access_state_e next_acc_state;
   logic read_hit;
   logic idle;
   logic int_go;
   logic call_go;
   logic ret_go;
   logic restore;
   logic dir_go;
   logic dir_rd_go;
   logic ind_rd_go;
   logic ind_wr_go;
   logic [PTR_W-1:0] sel_ptr;
   logic ptr_prog;
   logic [12:0] ptr_map;
   logic [PC_W-1:0] stk_top;
   logic [DEPTH_W-1:0] depth;
   logic stk_ovf;
   logic stk_unf;
   logic [7:0] work_sh;
   logic [BANK_W-1:0] bank_sh;
   logic [PTR_W-1:0] ptr0_sh;
   logic [PTR_W-1:0] ptr1_sh;

   // requests are only taken between accesses; the core must hold off while busy
   assign idle = acc_state == ACC_IDLE && !soft_reset;
   assign int_go = idle && int_req;
   assign call_go = idle && !int_req && call;
   assign ret_go = idle && !int_req && !call && (ret || retfie);
   assign restore = ret_go && retfie;
   assign dir_go = idle && (dir_rd || dir_wr);
   assign dir_rd_go = idle && dir_rd;
   assign ind_rd_go = idle && !dir_go && ind_rd;
   assign ind_wr_go = idle && !dir_go && !ind_rd && ind_wr;
   assign sel_ptr = ind_sel ? ptr1 : ptr0;
   assign ptr_prog = sel_ptr[PTR_PROG_BIT];
   assign ptr_map = map_pointer(sel_ptr);

   return_stack u_stack (
      .clk(clk),
      .reset_n(reset_n),
      .clear(soft_reset),
      .push(int_go || call_go),
      .pop(ret_go),
      .push_addr(int_go ? pc : pc + 15'h0001),
      .top_addr(stk_top),
      .depth(depth),
      .overflow(stk_ovf),
      .underflow(stk_unf)
   );

   context_shadow u_shadow (
      .clk(clk),
      .reset_n(reset_n),
      .save(int_go),
      .work_in(wreg),
      .bank_in(bank),
      .ptr0_in(ptr0),
      .ptr1_in(ptr1),
      .work_sh(work_sh),
      .bank_sh(bank_sh),
      .ptr0_sh(ptr0_sh),
      .ptr1_sh(ptr1_sh)
   );

   always_comb begin
      if (soft_reset) begin
         next_pc = RESET_VECTOR;
      end else if (!idle) begin
         next_pc = pc;
      end else if (int_req) begin
         next_pc = INT_VECTOR;
      end else if (call) begin
         next_pc = call_target;
      end else if (ret || retfie) begin
         next_pc = stk_top;
      end else if (jump) begin
         next_pc = jump_target;
      end else if (step) begin
         next_pc = pc + 15'h0001;
      end else begin
         next_pc = pc;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc <= RESET_VECTOR;
      end else begin
         pc <= next_pc;
      end
   end

   // the pc keeps all 15 bits; only the flash address folds into 4K words
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_addr <= RESET_VECTOR;
      end else if (ind_rd_go && ptr_prog) begin
         prog_addr <= sel_ptr[14:0] & PROG_TOP;
      end else if (acc_state != ACC_PROG_EXTRA) begin
         prog_addr <= next_pc & PROG_TOP;
      end
   end

   always_comb begin
      case (acc_state)
         ACC_IDLE: begin
            if (ind_rd_go && ptr_prog) begin
               next_acc_state = ACC_PROG_EXTRA;
            end else if (ind_rd_go || dir_rd_go) begin
               next_acc_state = ACC_DATA;
            end else begin
               next_acc_state = ACC_IDLE;
            end
         end
         ACC_PROG_EXTRA: next_acc_state = ACC_PROG_LATCH;
         default: next_acc_state = ACC_IDLE;
      endcase
      if (soft_reset) begin
         next_acc_state = ACC_IDLE;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_state <= ACC_IDLE;
         busy <= 1'b0;
      end else begin
         acc_state <= next_acc_state;
         busy <= next_acc_state != ACC_IDLE;
      end
   end

   // unmapped pointer targets read as zero and swallow writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_rd <= 1'b0;
         data_wr <= 1'b0;
         data_addr <= 12'h000;
         data_wdata <= 8'h00;
         read_hit <= 1'b0;
      end else begin
         data_rd <= dir_rd_go || (ind_rd_go && !ptr_prog && ptr_map[12]);
         data_wr <= (idle && dir_wr) || (ind_wr_go && !ptr_prog && ptr_map[12]);
         if (dir_go) begin
            data_addr <= {bank, dir_ofs};
         end else if (ind_rd_go || ind_wr_go) begin
            data_addr <= ptr_map[11:0];
         end
         data_wdata <= wr_data;
         read_hit <= dir_rd_go || ptr_map[12];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wreg <= WORK_RESET;
      end else if (acc_state == ACC_DATA) begin
         wreg <= read_hit ? data_rdata : 8'h00;
      end else if (acc_state == ACC_PROG_LATCH) begin
         wreg <= prog_rdata[7:0];
      end else if (restore) begin
         wreg <= work_sh;
      end else if (reg_wr && reg_addr == REG_WORK) begin
         wreg <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr0 <= PTR_RESET;
         ptr1 <= PTR_RESET;
         bank <= BANK_RESET;
      end else if (restore) begin
         ptr0 <= ptr0_sh;
         ptr1 <= ptr1_sh;
         bank <= bank_sh;
      end else if (reg_wr) begin
         if (reg_addr == REG_PTR0) ptr0 <= reg_wdata;
         if (reg_addr == REG_PTR1) ptr1 <= reg_wdata;
         if (reg_addr == REG_BANK) bank <= reg_wdata[4:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_stack_reset <= CTRL_RESET;
         mask <= MASK_RESET;
      end else if (reg_wr) begin
         if (reg_addr == REG_CTRL) ctrl_stack_reset <= reg_wdata[CTRL_STACK_RESET_BIT];
         if (reg_addr == REG_MASK) mask <= reg_wdata[1:0];
      end
   end

   // flags survive the software reset so firmware can see why it restarted
   assign power_control_register_set = {stk_unf, stk_ovf};
   assign power_control_register_clr = (reg_wr && reg_addr == REG_POWER_CONTROL_REGISTER) ? reg_wdata[1:0] : 2'h0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         power_control_register <= POWER_CONTROL_REGISTER_RESET;
         irq <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         power_control_register <= (power_control_register & ~power_control_register_clr) | power_control_register_set;
         irq <= |(power_control_register & mask);
         soft_reset <= (stk_ovf || stk_unf) && ctrl_stack_reset;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: reg_rdata <= {15'h0000, ctrl_stack_reset};
            REG_POWER_CONTROL_REGISTER: reg_rdata <= {14'h0000, power_control_register};
            REG_MASK: reg_rdata <= {14'h0000, mask};
            REG_PTR0: reg_rdata <= ptr0;
            REG_PTR1: reg_rdata <= ptr1;
            REG_BANK: reg_rdata <= {11'h000, bank};
            REG_WORK: reg_rdata <= {8'h00, wreg};
            REG_PC: reg_rdata <= {1'b0, pc};
            REG_DEPTH: reg_rdata <= {11'h000, depth};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_depth_bound;
      depth <= DEPTH_W'(STACK_DEPTH);
   endproperty
   a_depth_bound: assert property (p_depth_bound) else $error("stack depth beyond 16");
   property p_ovf_flag;
      stk_ovf |=> power_control_register[POWER_CONTROL_REGISTER_OVF_BIT] && depth == 5'h10;
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");
   property p_unf_flag;
      stk_unf |=> power_control_register[POWER_CONTROL_REGISTER_UNF_BIT] && depth == 5'h00;
   endproperty
   a_unf_flag: assert property (p_unf_flag) else $error("underflow flag not set");
   property p_soft_reset;
      (stk_ovf || stk_unf) && ctrl_stack_reset |=> soft_reset ##1 pc == RESET_VECTOR;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("stack error reset missing");
   property p_prog_extra;
      ind_rd_go && ptr_prog |=> busy [*2] ##1 !busy;
   endproperty
   a_prog_extra: assert property (p_prog_extra) else $error("program read not 2 cycles");
   property p_data_one;
      ind_rd_go && !ptr_prog |=> busy ##1 !busy;
   endproperty
   a_data_one: assert property (p_data_one) else $error("data read not 1 cycle");
   property p_wrap;
      prog_addr <= PROG_TOP;
   endproperty
   a_wrap: assert property (p_wrap) else $error("program address above top");
   property p_int_vec;
      int_go |=> pc == INT_VECTOR && prog_addr == INT_VECTOR;
   endproperty
   a_int_vec: assert property (p_int_vec) else $error("interrupt vector wrong");
   property p_prog_sel;
      ind_rd_go && ptr_prog |=> !data_rd && prog_addr == ($past(sel_ptr[14:0]) & PROG_TOP);
   endproperty
   a_prog_sel: assert property (p_prog_sel) else $error("pointer read not from flash");
   property p_low_byte;
      ind_rd_go && ptr_prog ##2 1'b1 |=> wreg == $past(prog_rdata[7:0]);
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("working reg not low byte");
   property p_no_prog_write;
      ind_wr_go && ptr_prog |=> !data_wr;
   endproperty
   a_no_prog_write: assert property (p_no_prog_write) else $error("flash write leaked");
   property p_shadow;
      restore |=> wreg == $past(work_sh) && ptr0 == $past(ptr0_sh) && bank == $past(bank_sh);
   endproperty
   a_shadow: assert property (p_shadow) else $error("context not restored");
   property p_linear;
      ind_rd_go && sel_ptr == LIN_BASE |=> data_rd && data_addr == {5'h00, GPR_FIRST};
   endproperty
   a_linear: assert property (p_linear) else $error("linear base mapped wrong");
   property p_bank;
      dir_rd_go |=> data_rd && data_addr == {$past(bank), $past(dir_ofs)};
   endproperty
   a_bank: assert property (p_bank) else $error("direct address wrong");
   property p_ret;
      ret_go && depth != 5'h00 |=> pc == $past(stk_top) && depth == $past(depth) - 5'h01;
   endproperty
   a_ret: assert property (p_ret) else $error("return did not pop");

   c_prog_read: cover property (ind_rd_go && ptr_prog ##3 !busy);
   c_overflow: cover property (stk_ovf ##1 soft_reset);
   c_int_ret: cover property (int_go ##[1:20] restore);
   c_linear: cover property (ind_rd_go && sel_ptr > LIN_BASE && sel_ptr <= LIN_END);
endmodule : cpu_program_memory_access

// *** verification/mem_model.sv ***
// flash program memory and banked data memory facing the addressing core
`timescale 1ns/1ps
module mem_model (
   input wire logic clk,
   input wire logic [14:0] prog_addr,
   output logic [13:0] prog_rdata,
   input wire logic [11:0] data_addr,
   input wire logic data_rd,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   output logic [7:0] data_rdata
);
   logic [7:0] mem [4096];
   logic [7:0] last;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i * 7 + 3);
      end
      last = 8'h00;
   end
   // only 4K words exist, so upper address bits are not decoded
   assign prog_rdata = 14'(prog_addr[11:0] * 13 + 5) ^ 14'h2A5A;
   // released bus shows the inverse of the last byte so stale data never matches
   assign data_rdata = data_rd ? mem[data_addr] : ~last;
   always @(posedge clk) begin
      if (data_rd) begin
         last <= mem[data_addr];
      end
      if (data_wr) begin
         mem[data_addr] <= data_wdata;
      end
   end
endmodule : mem_model

// *** verification/test_cpu_program_memory_access.sv ***
// self-checking bench for the program and data addressing core
`timescale 1ns/1ps
module test_cpu_program_memory_access;
   import cpu_addr_pkg::*;
   localparam int STEP = 0, JUMP = 1, CALL = 2, RET = 3, RETI = 4, INTR = 5;
   localparam int DRD = 6, DWR = 7, IRD = 8, IWR = 9;
   logic clk, reset_n, reg_wr, reg_rd, ind_sel, data_rd, data_wr, busy, soft_reset, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, p, sv[4];
   logic [9:0] ctl;
   logic [14:0] jt, ct, prog_addr, pc;
   logic [14:0] stk[$];
   logic [7:0] wr_data, data_rdata, data_wdata, wreg, nd;
   logic [7:0] emem [4096];
   logic [13:0] prog_rdata;
   logic [6:0] dir_ofs, nofs;
   logic [11:0] data_addr, a;
   logic [1:0] flags;
   logic nsel;
   logic [3:0] sh_a[4] = '{REG_WORK, REG_BANK, REG_PTR0, REG_PTR1};
   logic [15:0] sh_m[4] = '{16'h00FF, 16'h001F, 16'hFFFF, 16'hFFFF};
   int errors, total_checks, cycles, seed, n;

   cpu_program_memory_access dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .step(ctl[STEP]), .jump(ctl[JUMP]), .jump_target(jt), .call(ctl[CALL]),
      .call_target(ct), .ret(ctl[RET]), .retfie(ctl[RETI]), .int_req(ctl[INTR]),
      .dir_rd(ctl[DRD]), .dir_wr(ctl[DWR]), .dir_ofs(dir_ofs), .ind_rd(ctl[IRD]),
      .ind_wr(ctl[IWR]), .ind_sel(ind_sel), .wr_data(wr_data), .prog_rdata(prog_rdata),
      .data_rdata(data_rdata), .prog_addr(prog_addr), .data_addr(data_addr),
      .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata), .wreg(wreg),
      .busy(busy), .soft_reset(soft_reset), .irq(irq));
   mem_model mem (.clk(clk), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
      .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
      .data_wdata(data_wdata), .data_rdata(data_rdata));

   task conclude;
      if (errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [13:0] pw(input logic [11:0] x);
      return 14'(x * 13 + 5) ^ 14'h2A5A;
   endfunction : pw

   // reference pc and stack; an overflowing push is dropped, an empty pop gives 0000h
   function automatic void model(input int b, input logic [14:0] t);
      if (b == CALL || b == INTR) begin
         if (stk.size() == STACK_DEPTH) flags[0] = 1'b1;
         else stk.push_back(b == CALL ? pc + 15'h1 : pc);
         pc = (b == CALL) ? t : INT_VECTOR;
      end else if (b == RET || b == RETI) begin
         if (stk.size() == 0) flags[1] = 1'b1;
         pc = (stk.size() == 0) ? 15'h0000 : stk.pop_back();
      end else if (b == STEP) begin
         pc = pc + 15'h1;
      end else if (b == JUMP) begin
         pc = t;
      end
   endfunction : model

   task wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rdchk(input logic [3:0] ad, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask : rdchk

   // one-cycle request; returns in the cycle after it was taken
   task go(input int b, input logic [14:0] t = 15'h0000);
      @(posedge clk);
      ctl <= 10'(1) << b;
      jt <= t;
      ct <= t;
      ind_sel <= nsel;
      wr_data <= nd;
      dir_ofs <= nofs;
      @(posedge clk);
      ctl <= 10'h000;
      model(b, t);
      @(negedge clk);
   endtask : go

   task idle;
      for (int k = 0; k < 8 && busy !== 1'b0; k++) @(negedge clk);
   endtask : idle

   task cpc;
      chk(16'(prog_addr), 16'(pc & PROG_TOP));
   endtask : cpc

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         conclude();
      end
   end

   initial begin
      seed = 79225;
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, ctl, jt, ct, nsel, nd, nofs} = '0;
      {ind_sel, wr_data, dir_ofs, pc, flags, errors, total_checks} = '0;
      for (int i = 0; i < 4096; i++) emem[i] = 8'(i * 7 + 3);
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      cpc();
      for (int i = 0; i < 10; i++) rdchk(4'(i), 16'h0000);
      go(JUMP, 15'h7FFE);
      cpc();
      rdchk(REG_PC, 16'h7FFE);
      go(STEP);
      cpc();
      go(STEP);
      cpc();
      repeat (6) begin
         go(CALL, 15'($random(seed)));
         cpc();
      end
      repeat (6) begin
         go(RET);
         cpc();
      end
      // shadows must survive overwrites made inside the handler
      for (int i = 0; i < 4; i++) begin
         sv[i] = 16'($random(seed)) & sh_m[i];
         wr(sh_a[i], sv[i]);
      end
      go(INTR);
      cpc();
      for (int i = 0; i < 4; i++) wr(sh_a[i], ~sv[i] & sh_m[i]);
      go(RETI);
      cpc();
      for (int i = 0; i < 4; i++) rdchk(sh_a[i], sv[i]);
      wr(REG_MASK, 16'h0003);
      repeat (17) go(CALL, 15'($random(seed)));
      rdchk(REG_DEPTH, 16'd16);
      rdchk(REG_POWER_CONTROL_REGISTER, 16'(flags));
      chk(16'(irq), 16'h0001);
      wr(REG_POWER_CONTROL_REGISTER, 16'h0001);
      flags = 2'b00;
      repeat (2) @(negedge clk);
      chk(16'(irq), 16'h0000);
      repeat (17) begin
         go(RET);
         cpc();
      end
      rdchk(REG_POWER_CONTROL_REGISTER, 16'(flags));
      wr(REG_MASK, 16'h0001);
      repeat (2) @(negedge clk);
      chk(16'(irq), 16'h0000);
      wr(REG_POWER_CONTROL_REGISTER, 16'h0003);
      wr(REG_CTRL, 16'h0001);
      repeat (17) go(CALL, 15'($random(seed)));
      for (int k = 0; k < 4 && soft_reset !== 1'b1; k++) @(negedge clk);
      chk(16'(soft_reset), 16'h0001);
      @(negedge clk);
      pc = RESET_VECTOR;
      stk.delete();
      cpc();
      rdchk(REG_DEPTH, 16'h0000);
      wr(REG_CTRL, 16'h0000);
      wr(REG_POWER_CONTROL_REGISTER, 16'h0003);
      for (int j = 0; j < 6; j++) begin
         nsel = 1'($random(seed));
         nd = 8'($random(seed));
         p = 16'($random(seed)) & 16'h0FFF;
         wr(nsel ? REG_PTR1 : REG_PTR0, p);
         go(IWR);
         chk({data_wr, 3'b000, data_addr}, {1'b1, 3'b000, p[11:0]});
         chk(16'(data_wdata), 16'(nd));
         emem[p[11:0]] = nd;
         go(IRD);
         idle();
         chk(16'(wreg), 16'(nd));
         n = (j < 2) ? j * 2479 : $unsigned($random(seed)) % 2480;
         a = {5'(n / 80), 7'(32 + n % 80)};
         wr(nsel ? REG_PTR1 : REG_PTR0, 16'h2000 + 16'(n));
         go(IRD);
         chk({data_rd, 3'b000, data_addr}, {1'b1, 3'b000, a});
         idle();
         chk(16'(wreg), 16'(emem[a]));
         p = 16'h8000 | 16'($random(seed));
         wr(nsel ? REG_PTR1 : REG_PTR0, p);
         go(IRD);
         chk({busy, 15'(prog_addr)}, {1'b1, 15'(p[11:0])});
         @(negedge clk);
         chk(16'(busy), 16'h0001);
         @(negedge clk);
         chk(16'(busy), 16'h0000);
         chk(16'(wreg), 16'(pw(p[11:0]) & 14'h00FF));
         cpc();
         go(IWR);
         chk(16'(data_wr), 16'h0000);
         idle();
         nofs = 7'($random(seed));
         a = {5'($random(seed)), nofs};
         wr(REG_BANK, 16'(a[11:7]));
         go(DWR);
         chk({data_wr, 3'b000, data_addr}, {1'b1, 3'b000, a});
         emem[a] = nd;
         go(DRD);
         idle();
         chk(16'(wreg), 16'(nd));
      end
      // a pointer between the direct and linear windows reaches no memory
      wr(REG_PTR0, 16'h1000);
      nsel = 1'b0;
      go(IRD);
      chk(16'(data_rd), 16'h0000);
      idle();
      chk(16'(wreg), 16'h0000);
      conclude();
   end
endmodule : test_cpu_program_memory_access
